// ==== verilog/afp_pkg.sv ====
package afp_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LOOP_CONFIG  = 8'h00;
    localparam logic [7:0] IDX_FAN_CHAR     = 8'h20;
    localparam logic [7:0] IDX_MIN_DUTY     = 8'h22;
    localparam logic [7:0] IDX_FILTER_CTRL  = 8'h23;
    localparam logic [7:0] IDX_LOCAL_THR    = 8'h24;
    localparam logic [7:0] IDX_REMOTE_THR   = 8'h25;
    localparam logic [7:0] IDX_LOOP_STATUS  = 8'h26;

    // values after reset
    localparam logic [7:0] RST_LOOP_CONFIG  = 8'h80;
    localparam logic [7:0] RST_FAN_CHAR     = 8'h1D;
    localparam logic [7:0] RST_MIN_DUTY     = 8'h05;
    localparam logic [7:0] RST_FILTER_CTRL  = 8'h10;
    localparam logic [7:0] RST_LOCAL_THR    = 8'h43;
    localparam logic [7:0] RST_REMOTE_THR   = 8'h63;

    // writable bits
    localparam logic [7:0] MASK_LOOP_CONFIG = 8'hE0;
    localparam logic [7:0] MASK_MIN_DUTY    = 8'h0F;
    localparam logic [7:0] MASK_FILTER_CTRL = 8'hFD;

    // field positions
    localparam int unsigned CFG_AUTO_BIT     = 7;
    localparam int unsigned CFG_SEL_LSB      = 5;
    localparam int unsigned CHR_SPIN_LSB     = 0;
    localparam int unsigned CHR_FREQ_LSB     = 3;
    localparam int unsigned FLT_EN_BIT       = 0;
    localparam int unsigned FLT_RATE_LSB     = 2;
    localparam int unsigned FLT_RAMP_LSB     = 5;
    localparam int unsigned FLT_SPIN_DIS_BIT = 7;
    localparam int unsigned THR_FAN_ON_TEMPERATURE_LSB     = 3;

    localparam logic [1:0] SEL_REMOTE_ONLY  = 2'h0;
    localparam logic [1:0] SEL_FASTEST      = 2'h3;
    localparam logic [2:0] SPAN_MAX_CODE    = 3'h4;
    localparam logic [2:0] RATE_REF_CODE    = 3'h4;
    localparam logic [7:0] PWM_SLOTS        = 8'hF0;
    localparam logic [7:0] DUTY_CODE_SLOTS  = 8'h10;
    localparam logic [5:0] SLOPE_SLOTS_5C   = 6'h20;
    localparam logic [5:0] SLOPE_SLOTS_80C  = 6'h02;

    // pwm frequency per code in millihertz
    typedef int unsigned afp_cyc8_t [8];
    localparam afp_cyc8_t PWM_FREQ_MHZ = '{11700, 15600, 23400, 31250,
                                           37500, 46900, 62500, 93500};

    // slot length is rounded down so the period never runs long
    function automatic afp_cyc8_t afp_slot_table();
        afp_cyc8_t t;
        for (int i = 0; i < 8; i++)
        begin
            t[i] = int'((64'(CLK_HZ) * 64'd1000) / (64'(PWM_FREQ_MHZ[i]) * 64'd240));
        end
        return t;
    endfunction
    localparam afp_cyc8_t PWM_SLOT_CYC_DEF = afp_slot_table();

    localparam int unsigned SPINUP_UNIT_MS   = 200;
    localparam int unsigned SPINUP_UNIT_CYC  = CLK_HZ / 1000 * SPINUP_UNIT_MS;
    typedef logic [5:0] afp_mult8_t [8];
    localparam afp_mult8_t SPINUP_MULT = '{6'h01, 6'h02, 6'h03, 6'h04,
                                           6'h05, 6'h0A, 6'h14, 6'h28};

    // one temperature update per second at the reference sample rate
    localparam int unsigned UPDATE_REF_S     = 1;
    localparam int unsigned UPDATE_REF_CYC   = CLK_HZ * UPDATE_REF_S;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } afp_ahb_req_t;

    typedef struct packed {
        logic [7:0] local_temp;
        logic [7:0] remote_temp;
    } afp_temps_t;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  chr;
        logic [7:0]  mindc;
        logic [7:0]  flt;
        logic [7:0]  lthr;
        logic [7:0]  rthr;
        logic [7:0]  duty;
        logic [7:0]  target;
        logic [7:0]  applied;
        logic [15:0] slot_cyc;
        logic [7:0]  slot_idx;
        logic [31:0] tick_cnt;
        logic [31:0] spin_cnt;
        logic        pwm;
        logic        ph_valid;
        logic        ph_write;
        logic [7:0]  ph_idx;
        logic [31:0] rdata;
    } afp_state_t;

endpackage

// ==== verilog/afp_fan_loop.sv ====
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
// Summary of operation
// - config bit 7 selects automatic control when 1, software when 0; resets to 1.
// - select 00 uses remote loop only; 11 uses larger of both loops.
// - spin-up code 000..111 gives 200ms to 8s; reset code 101.
// - pwm frequency code 000..111 gives 11.7 to 93.5 Hz; reset 011.
// - speed range code picks divisor 1, 2, 4 or 8; stored for tach.
// - four-bit minimum duty code applies at turn-on temperature; reset 0x05.
// - local turn-on temperature is code times 4 C; reset 01000.
// - local span codes 000..100 mean 5, 10, 20, 40, 80 C.
// - remote channel has its own turn-on temperature, code times 4 C.
// - remote channel has its own span with the same coding.
// - unfiltered loop applies each new duty straight away.
// - filter register bit 0 enables filtered mode.
// - pwm period is 240 slots; one slot is the smallest duty step.
// - ramp field picks step of 1, 2, 4 or 8 slots.
// - filtered step moves stored duty toward new target and keeps the result.
// - sample rate field selects 87.5 Hz to 11.2 kHz; reset 1.4 kHz.
// - updates per second are 0.0625 up to 8 over the eight codes.
// - one filter iteration per temperature update.
// - ramp codes 00, 01, 10, 11 mean 1, 2, 4, 8 slots.
// - sample rate codes double from 87.5 Hz to 11.2 kHz.
// - duty codes 0..15 map linearly to 0..100 percent.
// - duty rises linearly; full speed at turn-on plus (15-min)*span/10.
module afp_fan_loop #(
    parameter afp_pkg::afp_cyc8_t PWM_SLOT_CYC    = afp_pkg::PWM_SLOT_CYC_DEF,
    parameter int unsigned        UPDATE_REF_CYC  = afp_pkg::UPDATE_REF_CYC,
    parameter int unsigned        SPINUP_UNIT_CYC = afp_pkg::SPINUP_UNIT_CYC
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire afp_pkg::afp_ahb_req_t ahb_req,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire afp_pkg::afp_temps_t   temps,
    output logic                       pwm_out
);

    ////////////////////////////////////////////////////////////////////////////

    localparam afp_pkg::afp_state_t ST_RESET = '{
        cfg      : afp_pkg::RST_LOOP_CONFIG,
        chr      : afp_pkg::RST_FAN_CHAR,
        mindc    : afp_pkg::RST_MIN_DUTY,
        flt      : afp_pkg::RST_FILTER_CTRL,
        lthr     : afp_pkg::RST_LOCAL_THR,
        rthr     : afp_pkg::RST_REMOTE_THR,
        tick_cnt : 32'(UPDATE_REF_CYC - 1),
        default  : '0
    };

    afp_pkg::afp_state_t st_q;
    afp_pkg::afp_state_t st_d;

    logic       auto_w;
    logic       filt_w;
    logic [1:0] sel_w;
    logic       tick_w;
    logic [7:0] loc_duty_w;
    logic [7:0] rem_duty_w;
    logic [7:0] target_w;
    logic [7:0] step_w;
    logic [2:0] rate_w;
    logic [31:0] period_w;

    ////////////////////////////////////////////////////////////////////////////
    // one channel's loop: linear from minimum duty at turn-on to full scale

    function automatic logic [7:0] loop_duty(
        input logic [7:0] temp,
        input logic [7:0] thr,
        input logic [3:0] minimum_duty_code
    );
        logic [7:0]  fan_on_temperature;
        logic [5:0]  slope;
        logic [13:0] lin;
        fan_on_temperature  = {1'b0, thr[7:afp_pkg::THR_FAN_ON_TEMPERATURE_LSB], 2'b00};
        // reserved span codes act as the widest span
        slope = (thr[2:0] > afp_pkg::SPAN_MAX_CODE) ? afp_pkg::SLOPE_SLOTS_80C
              : 6'(afp_pkg::SLOPE_SLOTS_5C >> thr[2:0]);
        // 16 slots per duty code, 10 codes per span: 160 slots per span
        lin   = 14'(minimum_duty_code) * 14'(afp_pkg::DUTY_CODE_SLOTS)
              + 14'(8'(temp - fan_on_temperature)) * 14'(slope);
        if (temp < fan_on_temperature)
        begin
            lin = 14'h0000;
        end
        if (lin > 14'(afp_pkg::PWM_SLOTS))
        begin
            lin = 14'(afp_pkg::PWM_SLOTS);
        end
        return lin[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    assign auto_w     = st_q.cfg[afp_pkg::CFG_AUTO_BIT];
    assign sel_w      = st_q.cfg[afp_pkg::CFG_SEL_LSB +: 2];
    assign filt_w     = st_q.flt[afp_pkg::FLT_EN_BIT];
    assign rate_w     = st_q.flt[afp_pkg::FLT_RATE_LSB +: 3];
    assign step_w     = 8'(8'h01 << st_q.flt[afp_pkg::FLT_RAMP_LSB +: 2]);
    assign loc_duty_w = loop_duty(temps.local_temp, st_q.lthr, st_q.mindc[3:0]);
    assign rem_duty_w = loop_duty(temps.remote_temp, st_q.rthr, st_q.mindc[3:0]);
    // 01 and 10 are not defined; they behave as remote only
    assign target_w   = (sel_w == afp_pkg::SEL_FASTEST && loc_duty_w > rem_duty_w)
                      ? loc_duty_w : rem_duty_w;
    // update period halves for each sample rate code above the reference
    assign period_w   = (rate_w < afp_pkg::RATE_REF_CODE)
                      ? 32'(UPDATE_REF_CYC << (afp_pkg::RATE_REF_CODE - rate_w))
                      : 32'(UPDATE_REF_CYC >> (rate_w - afp_pkg::RATE_REF_CODE));
    assign tick_w     = (st_q.tick_cnt == 32'h0000_0000);

    assign hrdata     = st_q.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign pwm_out    = st_q.pwm;

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic [8:0]  up_sum;
        logic [7:0]  wdat;
        logic        accept;
        logic [7:0]  rd_byte;
        up_sum  = 9'(st_q.duty) + 9'(step_w);
        wdat    = st_q.ph_write ? ahb_req.hwdata[7:0] : 8'h00;
        accept  = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
        rd_byte = 8'h00;
        st_d    = st_q;

        // bus data phase: writes land here
        if (st_q.ph_valid && st_q.ph_write)
        begin
            case (st_q.ph_idx)
                afp_pkg::IDX_LOOP_CONFIG:
                    st_d.cfg   = wdat & afp_pkg::MASK_LOOP_CONFIG;
                afp_pkg::IDX_FAN_CHAR:
                    st_d.chr   = wdat;
                afp_pkg::IDX_MIN_DUTY:
                    st_d.mindc = wdat & afp_pkg::MASK_MIN_DUTY;
                afp_pkg::IDX_FILTER_CTRL:
                    st_d.flt   = wdat & afp_pkg::MASK_FILTER_CTRL;
                afp_pkg::IDX_LOCAL_THR:
                    st_d.lthr  = wdat;
                afp_pkg::IDX_REMOTE_THR:
                    st_d.rthr  = wdat;
                default:
                    st_d.cfg   = st_q.cfg;
            endcase
        end

        // bus address phase; reads see a write landing in the same cycle
        st_d.ph_valid = accept;
        st_d.ph_write = accept && ahb_req.hwrite && (ahb_req.hsize == 3'h2)
                        && (ahb_req.haddr[31:10] == 22'h00_0000);
        st_d.ph_idx   = ahb_req.haddr[9:2];
        case (ahb_req.haddr[9:2])
            afp_pkg::IDX_LOOP_CONFIG: rd_byte = st_d.cfg;
            afp_pkg::IDX_FAN_CHAR:    rd_byte = st_d.chr;
            afp_pkg::IDX_MIN_DUTY:    rd_byte = st_d.mindc;
            afp_pkg::IDX_FILTER_CTRL: rd_byte = st_d.flt;
            afp_pkg::IDX_LOCAL_THR:   rd_byte = st_d.lthr;
            afp_pkg::IDX_REMOTE_THR:  rd_byte = st_d.rthr;
            default:                  rd_byte = 8'h00;
        endcase
        if (accept && !ahb_req.hwrite)
        begin
            if (ahb_req.haddr[31:10] != 22'h00_0000)
            begin
                st_d.rdata = 32'h0000_0000;
            end
            else if (ahb_req.haddr[9:2] == afp_pkg::IDX_LOOP_STATUS)
            begin
                st_d.rdata = {8'h00, st_q.target, st_q.applied, st_q.duty};
            end
            else
            begin
                st_d.rdata = {24'h00_0000, rd_byte};
            end
        end

        // temperature update timer
        st_d.tick_cnt = tick_w ? 32'(period_w - 32'h1) : 32'(st_q.tick_cnt - 32'h1);

        // duty loop runs once per update, only under automatic control
        if (tick_w && auto_w)
        begin
            st_d.target = target_w;
            if (!filt_w)
            begin
                st_d.duty = target_w;
            end
            else if (target_w > st_q.duty)
            begin
                st_d.duty = (up_sum > 9'(target_w)) ? target_w : up_sum[7:0];
            end
            else if (target_w < st_q.duty)
            begin
                st_d.duty = (st_q.duty < step_w || 8'(st_q.duty - step_w) < target_w)
                          ? target_w : 8'(st_q.duty - step_w);
            end
        end

        // full drive for the spin-up time when the fan starts from stop
        if (st_q.duty == 8'h00 && st_d.duty != 8'h00 && !st_q.flt[afp_pkg::FLT_SPIN_DIS_BIT])
        begin
            st_d.spin_cnt = 32'(spinup_mult(st_q.chr[2:0])) * 32'(SPINUP_UNIT_CYC);
        end
        else if (st_q.spin_cnt != 32'h0000_0000)
        begin
            st_d.spin_cnt = 32'(st_q.spin_cnt - 32'h1);
        end

        // pwm: 240 slots a period; duty is latched at the period start to avoid runt pulses
        if (st_q.slot_cyc == 16'h0000)
        begin
            st_d.slot_cyc = 16'(PWM_SLOT_CYC[st_q.chr[afp_pkg::CHR_FREQ_LSB +: 3]] - 1);
            if (st_q.slot_idx >= 8'(afp_pkg::PWM_SLOTS - 8'h01))
            begin
                st_d.slot_idx = 8'h00;
                st_d.applied  = (st_q.spin_cnt != 32'h0000_0000) ? afp_pkg::PWM_SLOTS
                              : st_q.duty;
            end
            else
            begin
                st_d.slot_idx = 8'(st_q.slot_idx + 8'h01);
            end
        end
        else
        begin
            st_d.slot_cyc = 16'(st_q.slot_cyc - 16'h0001);
        end
        st_d.pwm = (st_q.slot_idx < st_q.applied);
    end

    function automatic logic [5:0] spinup_mult(input logic [2:0] code);
        return afp_pkg::SPINUP_MULT[code];
    endfunction

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= ST_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    default clocking afp_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_manual_freeze_duty: assert property (
        !auto_w |=> $stable(st_q.duty))
        else $error("duty moved under software control");

    chk_unfiltered_apply: assert property (
        (tick_w && auto_w && !filt_w) |=> (st_q.duty == $past(target_w)))
        else $error("unfiltered duty not applied at update");

    chk_dual_takes_max: assert property (
        (tick_w && auto_w && !filt_w && sel_w == afp_pkg::SEL_FASTEST)
        |=> (st_q.duty == (($past(loc_duty_w) > $past(rem_duty_w))
                           ? $past(loc_duty_w) : $past(rem_duty_w))))
        else $error("dual select did not take the larger duty");

    chk_filter_step_up: assert property (
        (tick_w && auto_w && filt_w && target_w > st_q.duty)
        |=> (st_q.duty > $past(st_q.duty)) && (st_q.duty <= $past(target_w)))
        else $error("filtered duty failed to rise toward target");

    chk_filter_step_down: assert property (
        (tick_w && auto_w && filt_w && target_w < st_q.duty)
        |=> (st_q.duty < $past(st_q.duty)) && (st_q.duty >= $past(target_w)))
        else $error("filtered duty failed to fall toward target");

    chk_ramp_step_size: assert property (
        (tick_w && auto_w && filt_w)
        |=> (((st_q.duty >= $past(st_q.duty)) ? (st_q.duty - $past(st_q.duty))
                                              : ($past(st_q.duty) - st_q.duty))
             <= $past(step_w)))
        else $error("filtered step larger than ramp setting");

    chk_duty_in_range: assert property (
        st_q.duty <= afp_pkg::PWM_SLOTS && st_q.applied <= afp_pkg::PWM_SLOTS)
        else $error("duty beyond 240 slots");

    chk_update_only_tick: assert property (
        !tick_w |=> $stable(st_q.duty))
        else $error("duty changed between temperature updates");

    chk_full_duty_high: assert property (
        (st_q.applied == afp_pkg::PWM_SLOTS) [*2] |-> pwm_out)
        else $error("pwm low at full duty");

    chk_spinup_forces_full: assert property (
        (st_q.spin_cnt != 32'h0000_0000 && st_q.slot_cyc == 16'h0000
         && st_q.slot_idx == 8'hEF) |=> (st_q.applied == afp_pkg::PWM_SLOTS))
        else $error("spin-up period not driven at full duty");

    chk_bus_okay: assert property (
        hreadyout && !hresp)
        else $error("bus response not ready okay");

    cov_filtered_update: cover property (tick_w && auto_w && filt_w && target_w != st_q.duty);
    cov_spinup_start:    cover property (st_q.spin_cnt == 32'h0 ##1 st_q.spin_cnt != 32'h0);
    cov_dual_select:     cover property (tick_w && auto_w && sel_w == afp_pkg::SEL_FASTEST);

endmodule

// ==== verif/afp_fan_model.sv ====
`timescale 1ns/10ps
// fan seen as a load: sums pwm high cycles over windows of one pwm period
module afp_fan_model #(
    parameter int unsigned WIN_CYC = 960
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        pwm,
    output logic      [15:0] high_cyc
);
    logic [15:0] acc;
    logic [15:0] n;

    ////////////////////////////////////////////////////////////////////////////////
    // window length equals the period, so any phase gives slots times slot length
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc      <= 16'h0000;
            n        <= 16'h0000;
            high_cyc <= 16'h0000;
        end
        else if (n == 16'(WIN_CYC - 1))
        begin
            high_cyc <= acc + 16'(pwm);
            acc      <= 16'h0000;
            n        <= 16'h0000;
        end
        else
        begin
            acc <= acc + 16'(pwm);
            n   <= n + 16'h0001;
        end
    end
endmodule

// ==== verif/tb_auto_fan_pwm_filtered_loop.sv ====
`timescale 1ns/10ps
module tb_auto_fan_pwm_filtered_loop;
    typedef struct packed {
        logic [7:0] cfg, lthr, rthr, mindc, lt, rt, dexp;
    } afp_row_t;
    localparam int unsigned UPD = 2000;
    // {write, index, data, expected read}
    localparam logic [31:0] REGS [11] = '{32'h00_00_00_80, 32'h00_20_00_1D,
        32'h00_22_00_05, 32'h00_23_00_10, 32'h00_24_00_43, 32'h00_25_00_63,
        32'h00_01_00_00, 32'h01_00_7F_60, 32'h01_22_FF_0F, 32'h01_23_FE_FC,
        32'h01_30_AA_00};
    // {cfg, local thr, remote thr, min duty, local t, remote t, duty slots}
    localparam afp_row_t ROWS [10] = '{56'h80_00_2B_05_64_1E_78,
        56'hE0_00_2B_05_64_1E_F0, 56'hE0_08_2B_05_07_1E_B0,
        56'h80_00_2B_05_00_0A_00, 56'h80_00_2B_08_00_14_80,
        56'h80_00_2C_05_00_28_78, 56'h80_00_29_05_00_19_A0,
        56'h80_00_2A_05_00_1A_80, 56'h80_00_2B_0F_00_14_F0,
        56'h00_00_2B_05_00_1E_F0};

    logic                  hclk;
    logic                  hresetn;
    logic                  m_sel;
    logic                  m_wr;
    logic [1:0]            m_trans;
    logic [2:0]            m_size;
    logic [31:0]           m_addr;
    logic [31:0]           m_wdata;
    afp_pkg::afp_ahb_req_t bus;
    afp_pkg::afp_temps_t   temps;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  hresp;
    logic                  pwm_out;
    logic [15:0]           high_cyc;
    logic [31:0]           r;
    time                   t0;
    time                   t1;
    time                   t2;
    int                    mismatches;
    int                    cmp_count;
    int                    e;

    // single slave, so its hreadyout is the bus hready
    assign bus = {m_sel, m_addr, m_trans, m_wr, m_size, m_wdata, hreadyout};

    afp_fan_loop #(
        .PWM_SLOT_CYC   ('{default: 4}),
        .UPDATE_REF_CYC (UPD),
        .SPINUP_UNIT_CYC(100)
    ) i_afp_fan_loop (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ahb_req  (bus),
        .hrdata   (hrdata),
        .hreadyout(hreadyout),
        .hresp    (hresp),
        .temps    (temps),
        .pwm_out  (pwm_out)
    );

    afp_fan_model #(
        .WIN_CYC(960)
    ) i_afp_fan_model (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pwm     (pwm_out),
        .high_cyc(high_cyc)
    );

    always #5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        m_sel   <= 1'b1;
        m_trans <= 2'h2;
        m_addr  <= {22'h0, idx, 2'h0};
        m_wr    <= wr;
        m_size  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        m_sel   <= 1'b0;
        m_trans <= 2'h0;
        m_wdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        ahb(1'b1, idx, d, x);
    endtask

    // automatic bit stays clear while the loop fields change
    task automatic setup(input afp_row_t w);
        wr(afp_pkg::IDX_LOOP_CONFIG, 8'h00);
        wr(afp_pkg::IDX_LOCAL_THR, w.lthr);
        wr(afp_pkg::IDX_REMOTE_THR, w.rthr);
        wr(afp_pkg::IDX_MIN_DUTY, w.mindc);
        temps <= {w.lt, w.rt};
        wr(afp_pkg::IDX_LOOP_CONFIG, w.cfg);
    endtask

    // polls stored duty until it moves, then checks the size of the move
    task automatic step(input logic [7:0] stp, input logic [7:0] tgt, output time ts);
        logic [31:0] x;
        logic [7:0]  d0;
        logic [7:0]  ex;
        int          n;
        ahb(1'b0, afp_pkg::IDX_LOOP_STATUS, 8'h00, x);
        d0 = x[7:0];
        n  = 0;
        do
        begin
            ahb(1'b0, afp_pkg::IDX_LOOP_STATUS, 8'h00, x);
            n++;
        end
        while (x[7:0] === d0 && n < 3000);
        ts = $time;
        if (d0 < tgt)
            ex = (tgt - d0 > stp) ? d0 + stp : tgt;
        else
            ex = (d0 - tgt > stp) ? d0 - stp : tgt;
        chk({24'h0, x[7:0]}, {24'h0, ex});
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {m_sel, m_wr, m_trans, m_size, m_addr, m_wdata} = '0;
        temps = '0;
        mismatches = 0;
        cmp_count = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (REGS[i])
        begin
            if (REGS[i][24])
                wr(REGS[i][23:16], REGS[i][15:8]);
            ahb(1'b0, REGS[i][23:16], 8'h00, r);
            chk(r, {24'h0, REGS[i][7:0]});
        end
        // spin-up off, fastest updates, no filtering
        wr(afp_pkg::IDX_FILTER_CTRL, 8'h9C);
        foreach (ROWS[i])
        begin
            setup(ROWS[i]);
            repeat (4000) @(posedge hclk);
            ahb(1'b0, afp_pkg::IDX_LOOP_STATUS, 8'h00, r);
            chk({24'h0, r[7:0]}, {24'h0, ROWS[i].dexp});
            chk({16'h0, high_cyc}, {22'h0, ROWS[i].dexp, 2'h0});
        end
        // filtered descent by 8 toward a target that is not on the step grid
        wr(afp_pkg::IDX_LOOP_CONFIG, 8'h00);
        wr(afp_pkg::IDX_FILTER_CTRL, 8'hFD);
        setup(56'h80_00_2B_05_00_1F_7C);
        for (int i = 0; i < 15; i++)
            step(8'h08, 8'h7C, t0);
        @(posedge hclk);
        temps <= {8'h00, 8'h64};
        for (int i = 0; i < 3; i++)
        begin
            wr(afp_pkg::IDX_FILTER_CTRL, {1'b1, 2'(i), 5'b11101});
            repeat (2) step(8'(1 << i), 8'hF0, t0);
        end
        for (int c = 3; c < 8; c++)
        begin
            wr(afp_pkg::IDX_FILTER_CTRL, {3'b100, 3'(c), 2'b01});
            step(8'h01, 8'hF0, t0);
            step(8'h01, 8'hF0, t1);
            step(8'h01, 8'hF0, t2);
            e = int'((UPD * 16) >> c);
            chk(32'(((t2 - t1) / 10 + 3 >= e && (t2 - t1) / 10 <= e + 3) ? e : (t2 - t1) / 10),
                32'(e));
        end
        // second reset in mid-run while the pwm is toggling
        @(posedge hclk);
        hresetn <= 1'b0;
        temps   <= {8'h00, 8'h30};
        @(posedge hclk);
        #1;
        chk({31'h0, pwm_out}, 32'h0);
        chk(hrdata, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, afp_pkg::IDX_FILTER_CTRL, 8'h00, r);
        chk(r, 32'h10);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        // start from stop at 80 slots: spin-up must drive full duty for a while
        wr(afp_pkg::IDX_FAN_CHAR, 8'h1F);
        repeat (3100) @(posedge hclk);
        ahb(1'b0, afp_pkg::IDX_LOOP_STATUS, 8'h00, r);
        chk({24'h0, r[15:8]}, 32'hF0);
        chk({24'h0, r[7:0]}, 32'h50);
        repeat (4000) @(posedge hclk);
        ahb(1'b0, afp_pkg::IDX_LOOP_STATUS, 8'h00, r);
        chk({24'h0, r[15:8]}, 32'h50);
        end_sim();
    end

    initial
    begin
        repeat (99000) @(posedge hclk);
        mismatches++;
        end_sim();
    end
endmodule
